// ### verilog/xbs_pkg.sv
package xbs_pkg;

	// ==========================================
	// operation and size codes
	localparam logic [1:0] XBS_OP_NONE = 2'h0;
	localparam logic [1:0] XBS_OP_SWAP = 2'h1;
	localparam logic [1:0] XBS_OP_SEXT = 2'h2;

	localparam logic XBS_SIZE_WORD = 1'h0;
	localparam logic XBS_SIZE_ADDR = 1'h1;

	// ==========================================
	// register-map offsets (bytes) and fields
	localparam logic [3:0] XBS_REG_CTRL = 4'h0;
	localparam logic [3:0] XBS_REG_OPND = 4'h4;
	localparam logic [3:0] XBS_REG_RSLT = 4'h8;
	localparam logic [3:0] XBS_REG_STAT = 4'hc;

	localparam int XBS_CTRL_GO = 0;
	localparam int XBS_CTRL_OP_LO = 1;
	localparam int XBS_CTRL_SIZE = 3;
	localparam int XBS_CTRL_MEM = 4;

	localparam int XBS_SR_C = 0;
	localparam int XBS_SR_Z = 1;
	localparam int XBS_SR_N = 2;
	localparam int XBS_SR_GIE = 3;
	localparam int XBS_SR_CORE_OFF_BIT = 4;
	localparam int XBS_SR_OSCILLATOR_OFF_BIT = 5;
	localparam int XBS_SR_V = 8;
	localparam int XBS_STAT_BUSY = 16;

	localparam logic [31:0] XBS_BAD_ADDR_DATA = 32'hdeadbeef;

	// ==========================================
	// operand field positions
	localparam int XBS_SIGN_BIT = 7;
	localparam logic [11:0] XBS_ZERO_HI12 = 12'h000;
	localparam logic [3:0] XBS_ZERO_NIB = 4'h0;

	typedef enum logic [1:0] {
		XBS_IDLE,
		XBS_EXEC,
		XBS_DONE
	} xbs_state_type;

endpackage

// ### verilog/xbs_compose.sv
module xbs_compose
	import xbs_pkg::*;
(
	input wire logic [1:0] op_i,
	input wire logic size_i,
	input wire logic mem_i,
	input wire logic [31:0] opnd_i,
	input wire logic [15:0] sr_i,
	output logic [31:0] rslt_o,
	output logic [15:0] sr_o
);
	logic sgn;
	logic zero;
	logic neg;

	always_comb
	begin
		sgn = opnd_i[XBS_SIGN_BIT];
		rslt_o = opnd_i;
		sr_o = sr_i;
		zero = 1'b0;
		neg = 1'b0;
		case (op_i)
			XBS_OP_SWAP:
			begin
				rslt_o[15:0] = {opnd_i[7:0], opnd_i[15:8]};
				if (size_i == XBS_SIZE_ADDR)
				begin
					if (mem_i)
						rslt_o[31:20] = XBS_ZERO_HI12;
					else
						rslt_o[31:20] = XBS_ZERO_HI12;
					// 19:16 kept
				end
				else if (!mem_i)
				begin
					rslt_o[31:16] = {XBS_ZERO_HI12, XBS_ZERO_NIB};
				end
			end
			XBS_OP_SEXT:
			begin
				if (!mem_i || size_i == XBS_SIZE_ADDR)
				begin
					rslt_o = {XBS_ZERO_HI12, {12{sgn}}, opnd_i[7:0]};
					neg = rslt_o[19];
					zero = (rslt_o[19:0] == 20'h00000);
				end
				else
				begin
					rslt_o[15:0] = {{8{sgn}}, opnd_i[7:0]};
					neg = rslt_o[15];
					zero = (rslt_o[15:0] == 16'h0000);
				end
				sr_o[XBS_SR_N] = neg;
				sr_o[XBS_SR_Z] = zero;
				sr_o[XBS_SR_C] = ~zero;
				sr_o[XBS_SR_V] = 1'b0;
			end
			default:
			begin
				rslt_o = opnd_i;
			end
		endcase
	end
endmodule

// ### verilog/xbs_unit.sv
// Behaviour
// - byte swap in a register exchanges bits 15:8 with 7:0, both sizes
// - address-word byte swap in a register keeps bits 19:16
// - word byte swap in a register clears bits 19:16
// - address-word byte swap in memory writes zeros to bits 31:20
// - address-word byte swap in memory keeps 19:16, swaps the low bytes
// - word byte swap in memory swaps only the bytes of the 16-bit word
// - byte swap leaves N, Z, C and V unchanged
// - neither instruction touches the oscillator-off, core-off or irq-enable bits
// - sign extend in a register copies bit 7 into bits 19:8
// - address-word sign extend in memory fills 19:8 from bit 7, zeros 31:20
// - word sign extend in memory copies bit 7 into bits 15:8
// - sign extend sets N when the result is negative
// - sign extend sets Z when the result is zero
// - sign extend sets C to not Z and clears V
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
module xbs_unit
	import xbs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic busy_o
);
	// ==========================================
	// registers
	logic [1:0] op;
	logic size;
	logic mem;
	logic [31:0] opnd;
	logic [31:0] rslt;
	logic [15:0] sr;
	xbs_state_type state;
	logic go;
	logic acked;
	logic [31:0] comp_rslt;
	logic [15:0] comp_sr;
	logic [31:0] rd_mux;
	logic [31:0] mem_word;
	logic wr_take;
	logic [31:0] sr_merged;

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	xbs_compose u_compose (
		.op_i(op),
		.size_i(size),
		.mem_i(mem),
		.opnd_i(opnd),
		.sr_i(sr),
		.rslt_o(comp_rslt),
		.sr_o(comp_sr)
	);

	// ==========================================
	// bus handshake: one wait cycle, answer on second edge
	// writes land only at the edge where the master sees waitrequest low
	assign wr_take = avs_write_i && !avs_waitrequest_o;
	assign sr_merged = merge_be({16'h0000, sr}, avs_writedata_i, avs_byteenable_i);
	assign go = wr_take && avs_address_i == XBS_REG_CTRL
		&& avs_byteenable_i[0] && avs_writedata_i[XBS_CTRL_GO];

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			acked <= 1'b0;
		else if ((avs_read_i || avs_write_i) && !acked)
			acked <= 1'b1;
		else
			acked <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !acked);
	end

	always_comb
	begin
		case (avs_address_i)
			XBS_REG_CTRL: rd_mux = {27'h0000000, mem, size, op, 1'b0};
			XBS_REG_OPND: rd_mux = opnd;
			XBS_REG_RSLT: rd_mux = rslt;
			XBS_REG_STAT: rd_mux = {15'h0000, state != XBS_IDLE, sr};
			default: rd_mux = XBS_BAD_ADDR_DATA;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && !acked)
			avs_readdata_o <= rd_mux;
	end

	// ==========================================
	// control and operand registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			op <= XBS_OP_NONE;
			size <= XBS_SIZE_WORD;
			mem <= 1'b0;
		end
		else if (wr_take && avs_address_i == XBS_REG_CTRL
			&& avs_byteenable_i[0] && state == XBS_IDLE)
		begin
			op <= avs_writedata_i[XBS_CTRL_OP_LO +: 2];
			size <= avs_writedata_i[XBS_CTRL_SIZE];
			mem <= avs_writedata_i[XBS_CTRL_MEM];
		end
	end

	// memory form: operand word is read, composed, then written back in place
	always_comb
	begin
		mem_word = opnd;
		if (mem && size == XBS_SIZE_WORD)
			mem_word = {opnd[31:16], comp_rslt[15:0]};
		else
			mem_word = comp_rslt;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			opnd <= 32'h00000000;
		else if (state == XBS_EXEC && mem)
			opnd <= mem_word;
		else if (wr_take && avs_address_i == XBS_REG_OPND && state == XBS_IDLE)
			opnd <= merge_be(opnd, avs_writedata_i, avs_byteenable_i);
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			rslt <= 32'h00000000;
		else if (state == XBS_EXEC)
			rslt <= mem ? mem_word : comp_rslt;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			sr <= 16'h0000;
		else if (state == XBS_EXEC)
			sr <= comp_sr;
		else if (wr_take && avs_address_i == XBS_REG_STAT && state == XBS_IDLE)
			sr <= sr_merged[15:0];
	end

	// ==========================================
	// execute sequencer
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			state <= XBS_IDLE;
		else
			case (state)
				XBS_IDLE: if (go) state <= XBS_EXEC;
				XBS_EXEC: state <= XBS_DONE;
				XBS_DONE: state <= XBS_IDLE;
				default: state <= XBS_IDLE;
			endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			busy_o <= 1'b0;
		else
			busy_o <= (state == XBS_IDLE) ? go : (state == XBS_EXEC);
	end
endmodule

// ### test/xbs_unit_asserts.sv
module xbs_unit_asserts
	import xbs_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================
	// bus handshake
	rst_idle_a: assert property (disable iff (1'b0) sys_rst_i |=> avs_waitrequest_o && !busy_o)
		else $error("not idle after reset");
	ack_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("ack longer than one cycle");
	ack_req_a: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
		else $error("ack without request");
	rd_lat_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read ack latency");
	wr_lat_a: assert property ($rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("write ack latency");
	bad_addr_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0
		|-> avs_readdata_o == XBS_BAD_ADDR_DATA) else $error("unmapped read data");
	rd_hold_a: assert property (!(avs_read_i && !avs_waitrequest_o) && !$past(sys_rst_i)
		|-> $stable(avs_readdata_o)) else $error("read data moved");
	// ==========================================
	// operation timing
	busy_go_a: assert property (avs_write_i && !avs_waitrequest_o && !busy_o &&
		avs_address_i == XBS_REG_CTRL && avs_writedata_i[XBS_CTRL_GO] |-> ##[1:3] busy_o)
		else $error("operation did not start");
	busy_end_a: assert property ($rose(busy_o) |-> ##[1:4] !busy_o)
		else $error("operation did not end");
	rd_c: cover property (avs_read_i && !avs_waitrequest_o);
	wr_c: cover property (avs_write_i && !avs_waitrequest_o);
	op_c: cover property ($fell(busy_o));
endmodule

bind xbs_unit xbs_unit_asserts u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

// ### test/tb.sv
module tb
	import xbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, sys_rst_i = 1, rd = 0, wr = 0, wt, busy;
	logic [3:0] addr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q, o;
	logic [47:0] e;
	logic [4:0] c;
	logic [15:0] sr;
	int fails = 0, n_tests = 0, n;
	logic [31:0] opnd [4] = '{32'habc23456, 32'h00000080, 32'hfff5a000, 32'h1234567f};
	always #10 mclk_i = ~mclk_i;
	xbs_unit u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .busy_o(busy));
	// ==========================================
	// bus access and compare
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (wt !== 1'b0 && n < 50);
		if (n >= 50)
			fails++;
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		n_tests++;
		if (g !== ex)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, g);
		end
	endtask
	function automatic logic [47:0] expect_fn(input logic [4:0] k, input logic [31:0] v,
		input logic [15:0] s);
		logic [31:0] r;
		logic [15:0] f;
		f = s;
		if (k[2:1] == XBS_OP_SWAP)
			r = {12'h000, v[19:16], v[7:0], v[15:8]};
		else
		begin
			r = {12'h000, {12{v[7]}}, v[7:0]};
			f[XBS_SR_N] = v[7];
			f[XBS_SR_Z] = (v[7:0] == 8'h00);
			f[XBS_SR_C] = (v[7:0] != 8'h00);
			f[XBS_SR_V] = 1'b0;
		end
		if (k[4] && !k[3])
			r = {v[31:16], r[15:0]};
		else if (!k[3] && k[2:1] == XBS_OP_SWAP)
			r[19:16] = 4'h0;
		return {f, r};
	endfunction
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		fails++;
		finish_test;
	end
	// ==========================================
	// main sequence
	initial
	begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		acc(1'b0, XBS_REG_RSLT, 32'h0);
		chk("rslt reset", 32'h0, q);
		acc(1'b0, 4'h1, 32'h0);
		chk("unmapped", XBS_BAD_ADDR_DATA, q);
		for (int m = 0; m < 8; m++)
			for (int j = 0; j < 4; j++)
			begin
				c = {m[1], m[0], m[2] ? XBS_OP_SEXT : XBS_OP_SWAP, 1'b1};
				sr = j[0] ? 16'h013f : 16'h0000;
				o = opnd[j];
				acc(1'b1, XBS_REG_STAT, {16'h0, sr});
				acc(1'b1, XBS_REG_OPND, o);
				acc(1'b1, XBS_REG_CTRL, {27'h0, c});
				@(negedge mclk_i);
				chk("busy", 32'h1, {31'h0, busy});
				for (int p = 0; p < 20; p++)
				begin
					acc(1'b0, XBS_REG_STAT, 32'h0);
					if (q[XBS_STAT_BUSY] === 1'b0)
						break;
				end
				e = expect_fn(c, o, sr);
				acc(1'b0, XBS_REG_RSLT, 32'h0);
				chk("result", e[31:0], q);
				acc(1'b0, XBS_REG_STAT, 32'h0);
				chk("status", {15'h0, 1'b0, e[47:32]}, {15'h0, q[16:0]});
				acc(1'b0, XBS_REG_OPND, 32'h0);
				chk("write back", c[4] ? e[31:0] : o, q);
			end
		finish_test;
	end
endmodule
